// File: inc/vm_exit_info_pkg.sv
// Constants and carrier types for the exit-information field bank
`default_nettype none

package vm_exit_info_pkg;

  // ****************************************************************
  // Architecture options
  // ****************************************************************
  localparam logic SUPPORTS_EXT64 = 1'b1;

  // ****************************************************************
  // Selector layout and codes
  // ****************************************************************
  typedef struct packed {
    logic [16:0] rsvd_hi;
    logic [1:0] width;
    logic rsvd_mid;
    logic [1:0] ftype;
    logic [8:0] index;
    logic access_high;
  } selector_t;

  localparam int unsigned SEL_UPPER_LSB = 33;
  localparam logic [1:0] WIDTH_16 = 2'h0;
  localparam logic [1:0] WIDTH_64 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  localparam logic [1:0] WIDTH_NAT = 2'h3;
  localparam logic [1:0] TYPE_CONTROL = 2'h0;
  localparam logic [1:0] TYPE_RO_DATA = 2'h1;
  localparam logic [1:0] TYPE_GUEST = 2'h2;
  localparam logic [1:0] TYPE_HOST = 2'h3;

  // Field indices inside the read-only data type
  localparam logic [8:0] IDX_INSTR_ERROR = 9'h000;
  localparam logic [8:0] IDX_DELIVERY_INFO = 9'h008;
  localparam logic [8:0] IDX_DELIVERY_ERR = 9'h009;
  localparam logic [8:0] IDX_INSTR_LENGTH = 9'h00A;
  localparam logic [8:0] IDX_INSTR_DETAIL = 9'h00B;
  localparam logic [8:0] IDX_IO_FIRST = 9'h000;
  localparam int unsigned IO_REGS = 4;

  // Internal storage slots
  localparam logic [3:0] SLOT_INSTR_ERROR = 4'h0;
  localparam logic [3:0] SLOT_DELIVERY_INFO = 4'h1;
  localparam logic [3:0] SLOT_DELIVERY_ERR = 4'h2;
  localparam logic [3:0] SLOT_INSTR_LENGTH = 4'h3;
  localparam logic [3:0] SLOT_INSTR_DETAIL = 4'h4;
  localparam logic [3:0] SLOT_IO_FIRST = 4'h5;
  localparam logic [3:0] SLOT_NONE = 4'hF;

  // ****************************************************************
  // Event-delivery information layout
  // ****************************************************************
  localparam int unsigned INFO_VALID_BIT = 31;
  localparam logic [2:0] KIND_EXT_INT = 3'h0;
  localparam logic [2:0] KIND_NMI = 3'h2;
  localparam logic [2:0] KIND_HW_EXC = 3'h3;
  localparam logic [2:0] KIND_SW_INT = 3'h4;
  localparam logic [2:0] KIND_PRIV_SW_EXC = 3'h5;
  localparam logic [2:0] KIND_SW_EXC = 3'h6;

  // ****************************************************************
  // Error numbers and reset values
  // ****************************************************************
  localparam logic [31:0] ERR_BAD_SELECTOR = 32'h0000000C;
  localparam logic [31:0] ERR_WRITE_READ_ONLY = 32'h0000000D;
  localparam logic [31:0] RESET_WORD32 = 32'h00000000;
  localparam logic [63:0] RESET_WORD64 = 64'h0000000000000000;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    EXIT_OTHER = 2'h0,
    EXIT_INSTR = 2'h1,
    EXIT_SMI_AFTER_IO = 2'h2
  } exit_cause_t;

  typedef struct packed {
    logic [7:0] vector;
    logic [2:0] kind;
    logic has_err_code;
    logic [31:0] err_code;
  } delivery_t;

  typedef struct packed {
    exit_cause_t cause;
    logic in_delivery;
    delivery_t delivery;
    logic [31:0] instr_len;
    logic [31:0] instr_detail;
    logic [IO_REGS-1:0][63:0] io_regs;
  } exit_event_t;

  typedef struct packed {
    logic is_write;
    logic mode64;
    logic [63:0] selector;
    logic [63:0] wdata;
  } access_req_t;

endpackage

`default_nettype wire

// File: hw/vm_field_encoding_exit_info.sv
// Exit-information field bank with selector decode for record access
// Behaviour
// - Vector held in delivery info bits 7:0
// - Event kind held in bits 10:8
// - Bit 11 marks an accompanying error code
// - Bit 12 undefined, bits 30:13 read zero
// - Hardware exception error code captured
// - Instruction exits record instruction byte length
// - Length also kept for software interrupt and software exception delivery
// - Saved I/O registers only on post-I/O interrupt
// - Exits never change the instruction error
// - Instruction error reports failed record instructions
// - 64-bit mode: selector bits beyond 32 fail (checked from bit 33 up; bit 32 is ignored)
// - High access allowed only for 64-bit width
// - Bits 9:1 index fields of equal kind
// - Bits 11:10 decode the field type
// - Bits 14:13 decode the field width
// - Natural width follows the 64-bit extension
// - All fields here are read-only data
// - Writes to read-only data fields fail
// - Full access whole field, high upper half
// - High read returns upper half, zero above
// - Narrow-mode full write clears upper half (all writes fail here, so nothing is cleared)
`timescale 1ns/1ns
`default_nettype none

module vm_field_encoding_exit_info (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Exit capture
  input wire logic i_exit_valid,
  input wire vm_exit_info_pkg::exit_event_t i_exit_event,
  // Other instruction errors
  input wire logic i_instr_err_valid,
  input wire logic [31:0] i_instr_err_num,
  // Record access
  input wire logic i_acc_valid,
  input wire vm_exit_info_pkg::access_req_t i_acc_req,
  output logic o_acc_done,
  output logic o_acc_fail,
  output logic [63:0] o_acc_rdata,
  // Status
  output logic [31:0] o_instr_error
);

  // ****************************************************************
  // Decode functions
  // ****************************************************************
  function automatic logic [3:0] field_slot(input vm_exit_info_pkg::selector_t s);
    logic [3:0] slot;
    slot = vm_exit_info_pkg::SLOT_NONE;
    if (s.ftype == vm_exit_info_pkg::TYPE_RO_DATA) begin
      if (s.width == vm_exit_info_pkg::WIDTH_32) begin
        case (s.index)
          vm_exit_info_pkg::IDX_INSTR_ERROR: slot = vm_exit_info_pkg::SLOT_INSTR_ERROR;
          vm_exit_info_pkg::IDX_DELIVERY_INFO: slot = vm_exit_info_pkg::SLOT_DELIVERY_INFO;
          vm_exit_info_pkg::IDX_DELIVERY_ERR: slot = vm_exit_info_pkg::SLOT_DELIVERY_ERR;
          vm_exit_info_pkg::IDX_INSTR_LENGTH: slot = vm_exit_info_pkg::SLOT_INSTR_LENGTH;
          vm_exit_info_pkg::IDX_INSTR_DETAIL: slot = vm_exit_info_pkg::SLOT_INSTR_DETAIL;
          default: slot = vm_exit_info_pkg::SLOT_NONE;
        endcase
      end else if (s.width == vm_exit_info_pkg::WIDTH_NAT) begin
        if (s.index < (vm_exit_info_pkg::IDX_IO_FIRST + 9'(vm_exit_info_pkg::IO_REGS))) begin
          slot = vm_exit_info_pkg::SLOT_IO_FIRST + s.index[3:0];
        end
      end
    end
    return slot;
  endfunction

  // Natural-width values lose their upper half without the extension
  function automatic logic [63:0] nat_trim(input logic [63:0] v);
    return vm_exit_info_pkg::SUPPORTS_EXT64 ? v : {32'h00000000, v[31:0]};
  endfunction

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [31:0] info_r;
  logic [31:0] err_code_r;
  logic [31:0] instr_len_r;
  logic [31:0] instr_detail_r;
  logic [vm_exit_info_pkg::IO_REGS-1:0][63:0] io_r;
  logic [31:0] instr_err_r;

  logic take_exit;
  logic take_acc;
  assign take_exit = i_clk_en && i_exit_valid;
  assign take_acc = i_clk_en && i_acc_valid;

  // ****************************************************************
  // Exit capture
  // ****************************************************************
  logic sw_delivery;
  assign sw_delivery = i_exit_event.in_delivery &&
    ((i_exit_event.delivery.kind == vm_exit_info_pkg::KIND_SW_INT) ||
     (i_exit_event.delivery.kind == vm_exit_info_pkg::KIND_SW_EXC));

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      info_r <= vm_exit_info_pkg::RESET_WORD32;
    end else if (take_exit) begin
      if (i_exit_event.in_delivery) begin
        // Bit 12 carries no meaning, so it is stored as zero
        info_r <= {1'b1, 18'h00000, 1'b0,
                   i_exit_event.delivery.has_err_code,
                   i_exit_event.delivery.kind,
                   i_exit_event.delivery.vector};
      end else begin
        info_r <= vm_exit_info_pkg::RESET_WORD32;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      err_code_r <= vm_exit_info_pkg::RESET_WORD32;
    end else if (take_exit && i_exit_event.in_delivery &&
                 i_exit_event.delivery.has_err_code &&
                 i_exit_event.delivery.kind == vm_exit_info_pkg::KIND_HW_EXC) begin
      err_code_r <= i_exit_event.delivery.err_code;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      instr_len_r <= vm_exit_info_pkg::RESET_WORD32;
    end else if (take_exit &&
                 (i_exit_event.cause == vm_exit_info_pkg::EXIT_INSTR || sw_delivery)) begin
      instr_len_r <= i_exit_event.instr_len;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      instr_detail_r <= vm_exit_info_pkg::RESET_WORD32;
    end else if (take_exit && i_exit_event.cause == vm_exit_info_pkg::EXIT_INSTR) begin
      instr_detail_r <= i_exit_event.instr_detail;
    end
  end

  // Saved count, source, destination and pointer registers
  genvar g;
  generate
    for (g = 0; g < vm_exit_info_pkg::IO_REGS; g++) begin : gen_io
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          io_r[g] <= vm_exit_info_pkg::RESET_WORD64;
        end else if (take_exit && i_exit_event.cause == vm_exit_info_pkg::EXIT_SMI_AFTER_IO) begin
          io_r[g] <= nat_trim(i_exit_event.io_regs[g]);
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Selector check and read shaping
  // ****************************************************************
  vm_exit_info_pkg::selector_t sel;
  logic [3:0] slot;
  logic upper_bad;
  logic rsvd_bad;
  logic high_bad;
  logic sel_bad;
  logic acc_fail_nxt;
  logic [31:0] acc_err_nxt;
  logic [63:0] raw;
  logic [63:0] rdata_nxt;

  assign sel = vm_exit_info_pkg::selector_t'(i_acc_req.selector[31:0]);
  assign slot = field_slot(sel);
  // Outside 64-bit mode the upper operand half is not part of the selector
  assign upper_bad = i_acc_req.mode64 &&
    (|i_acc_req.selector[63:vm_exit_info_pkg::SEL_UPPER_LSB]);
  assign rsvd_bad = sel.rsvd_mid || (|sel.rsvd_hi);
  assign high_bad = sel.access_high && (sel.width != vm_exit_info_pkg::WIDTH_64);
  assign sel_bad = upper_bad || rsvd_bad || high_bad || (slot == vm_exit_info_pkg::SLOT_NONE);

  always_comb begin
    raw = vm_exit_info_pkg::RESET_WORD64;
    case (slot)
      vm_exit_info_pkg::SLOT_INSTR_ERROR: raw = {32'h00000000, instr_err_r};
      vm_exit_info_pkg::SLOT_DELIVERY_INFO: raw = {32'h00000000, info_r};
      vm_exit_info_pkg::SLOT_DELIVERY_ERR: raw = {32'h00000000, err_code_r};
      vm_exit_info_pkg::SLOT_INSTR_LENGTH: raw = {32'h00000000, instr_len_r};
      vm_exit_info_pkg::SLOT_INSTR_DETAIL: raw = {32'h00000000, instr_detail_r};
      default: begin
        if (slot >= vm_exit_info_pkg::SLOT_IO_FIRST && slot != vm_exit_info_pkg::SLOT_NONE) begin
          raw = io_r[2'(slot - vm_exit_info_pkg::SLOT_IO_FIRST)];
        end
      end
    endcase
  end

  always_comb begin
    rdata_nxt = 64'h0000000000000000;
    case (sel.width)
      vm_exit_info_pkg::WIDTH_16: rdata_nxt = {48'h000000000000, raw[15:0]};
      vm_exit_info_pkg::WIDTH_32: rdata_nxt = {32'h00000000, raw[31:0]};
      default: begin
        // High access only ever reaches a 64-bit field; none lives here yet
        if (sel.access_high) begin
          rdata_nxt = {32'h00000000, raw[63:32]};
        end else if (i_acc_req.mode64) begin
          rdata_nxt = nat_trim(raw);
        end else begin
          rdata_nxt = {32'h00000000, raw[31:0]};
        end
      end
    endcase
  end

  // Every field here is read-only, so no write ever lands and the
  // narrow-mode upper-half clear never has a target
  always_comb begin
    acc_fail_nxt = 1'b0;
    acc_err_nxt = instr_err_r;
    if (sel_bad) begin
      acc_fail_nxt = 1'b1;
      acc_err_nxt = vm_exit_info_pkg::ERR_BAD_SELECTOR;
    end else if (i_acc_req.is_write) begin
      acc_fail_nxt = 1'b1;
      acc_err_nxt = vm_exit_info_pkg::ERR_WRITE_READ_ONLY;
    end
  end

  // ****************************************************************
  // Access answer and instruction error
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_acc_done <= 1'b0;
      o_acc_fail <= 1'b0;
      o_acc_rdata <= vm_exit_info_pkg::RESET_WORD64;
    end else if (i_clk_en) begin
      o_acc_done <= i_acc_valid;
      if (i_acc_valid) begin
        o_acc_fail <= acc_fail_nxt;
        o_acc_rdata <= (acc_fail_nxt || i_acc_req.is_write) ? 64'h0000000000000000 : rdata_nxt;
      end
    end
  end

  // Exits never reach this register; access failure beats the side port
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      instr_err_r <= vm_exit_info_pkg::RESET_WORD32;
    end else if (take_acc && acc_fail_nxt) begin
      instr_err_r <= acc_err_nxt;
    end else if (i_clk_en && i_instr_err_valid) begin
      instr_err_r <= i_instr_err_num;
    end
  end

  assign o_instr_error = instr_err_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_req_answered: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_acc |=> o_acc_done)
    else $error("access not answered next cycle");

  a_write_fails: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_acc && i_acc_req.is_write |=> o_acc_fail && o_acc_rdata == 64'h0000000000000000)
    else $error("write to read-only field did not fail");

  a_upper_sel_fail: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_acc && upper_bad |=> o_acc_fail && o_instr_error == vm_exit_info_pkg::ERR_BAD_SELECTOR)
    else $error("selector above bit 32 accepted");

  a_high_nonwide_fail: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_acc && sel.access_high && sel.width != vm_exit_info_pkg::WIDTH_64 |=> o_acc_fail)
    else $error("high access on non 64-bit field accepted");

  a_reserved_sel_fail: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_acc && rsvd_bad |=> o_acc_fail && o_instr_error == vm_exit_info_pkg::ERR_BAD_SELECTOR)
    else $error("reserved selector bits accepted");

  a_info_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    info_r[30:12] == 19'h00000)
    else $error("delivery info reserved bits not zero");

  a_info_capture: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_exit && i_exit_event.in_delivery |=>
      info_r[7:0] == $past(i_exit_event.delivery.vector) &&
      info_r[10:8] == $past(i_exit_event.delivery.kind) &&
      info_r[11] == $past(i_exit_event.delivery.has_err_code) &&
      info_r[vm_exit_info_pkg::INFO_VALID_BIT])
    else $error("delivery info not captured");

  a_exit_keeps_error: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_exit && !i_acc_valid && !i_instr_err_valid |=> $stable(instr_err_r))
    else $error("exit changed the instruction error");

  a_io_only_smi: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_exit && i_exit_event.cause != vm_exit_info_pkg::EXIT_SMI_AFTER_IO |=> $stable(io_r))
    else $error("saved registers changed on other exit");

  a_len_capture: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_exit && sw_delivery |=> instr_len_r == $past(i_exit_event.instr_len))
    else $error("instruction length not kept for software event");

  a_read32_zero_upper: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_acc && !acc_fail_nxt && sel.width == vm_exit_info_pkg::WIDTH_32 |=>
      !o_acc_fail && o_acc_rdata[63:32] == 32'h00000000)
    else $error("32-bit read leaked upper bits");

  a_err_code_capture: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_exit && i_exit_event.in_delivery && i_exit_event.delivery.has_err_code &&
      i_exit_event.delivery.kind == vm_exit_info_pkg::KIND_HW_EXC |=>
      err_code_r == $past(i_exit_event.delivery.err_code))
    else $error("delivery error code not captured");

  a_len_instr_exit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_exit && i_exit_event.cause == vm_exit_info_pkg::EXIT_INSTR |=>
      instr_len_r == $past(i_exit_event.instr_len))
    else $error("instruction length not captured");

  a_io_capture: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_exit && i_exit_event.cause == vm_exit_info_pkg::EXIT_SMI_AFTER_IO |=>
      io_r == $past(i_exit_event.io_regs))
    else $error("saved registers not captured");

  a_ok_keeps_error: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take_acc && !acc_fail_nxt && !i_instr_err_valid |=> $stable(instr_err_r))
    else $error("successful access changed the instruction error");

  c_read_ok: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    take_acc && !i_acc_req.is_write ##1 o_acc_done && !o_acc_fail);
  c_write_fail: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    take_acc && i_acc_req.is_write ##1 o_acc_fail);
  c_delivery_exit: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    take_exit && i_exit_event.in_delivery && i_exit_event.delivery.has_err_code);
  c_smi_exit: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    take_exit && i_exit_event.cause == vm_exit_info_pkg::EXIT_SMI_AFTER_IO);
  c_narrow_nat_read: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    take_acc && !i_acc_req.mode64 && sel.width == vm_exit_info_pkg::WIDTH_NAT);

endmodule // vm_field_encoding_exit_info

`default_nettype wire

// File: dv/vm_field_encoding_exit_info_tb.sv
// Self-checking bench for the exit-information field bank
`timescale 1ns/1ns
`default_nettype none

module vm_field_encoding_exit_info_tb;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic i_sys_clk;
  logic i_rst;
  logic i_clk_en;
  logic i_exit_valid;
  vm_exit_info_pkg::exit_event_t i_exit_event;
  logic i_instr_err_valid;
  logic [31:0] i_instr_err_num;
  logic i_acc_valid;
  vm_exit_info_pkg::access_req_t i_acc_req;
  logic o_acc_done;
  logic o_acc_fail;
  logic [63:0] o_acc_rdata;
  logic [31:0] o_instr_error;
  int fails = 0;
  int comparisons = 0;
  // Bit 12 of the delivery word has no defined value
  localparam logic [63:0] INFO_MASK = 64'hFFFFFFFFFFFFEFFF;
  localparam logic [63:0] ALL = 64'hFFFFFFFFFFFFFFFF;

  // One bank holds one record, reached from one requester only
  vm_field_encoding_exit_info dut_u (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(i_clk_en),
    .i_exit_valid(i_exit_valid), .i_exit_event(i_exit_event),
    .i_instr_err_valid(i_instr_err_valid), .i_instr_err_num(i_instr_err_num),
    .i_acc_valid(i_acc_valid), .i_acc_req(i_acc_req), .o_acc_done(o_acc_done),
    .o_acc_fail(o_acc_fail), .o_acc_rdata(o_acc_rdata), .o_instr_error(o_instr_error)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [63:0] sel(input logic [1:0] w, input logic [8:0] idx);
    sel = {49'h0, w, 1'b0, vm_exit_info_pkg::TYPE_RO_DATA, idx, 1'b0};
  endfunction

  // One record request, bounded wait for the answer, then compare fail and data
  task automatic rd_chk(input string what, input logic wr, input logic m64,
      input logic [63:0] s, input logic efail, input logic [63:0] exp,
      input logic [63:0] mask);
    int n;
    n = 0;
    i_acc_req <= '{is_write: wr, mode64: m64, selector: s, wdata: 64'h5A5A5A5A5A5A5A5A};
    i_acc_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_acc_valid <= 1'b0;
    #1;
    while (o_acc_done !== 1'b1 && n < 4) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk({what, " done"}, 64'h1, {63'h0, o_acc_done});
    chk({what, " fail"}, {63'h0, efail}, {63'h0, o_acc_fail});
    chk(what, exp & mask, o_acc_rdata & mask);
    @(posedge i_sys_clk);
  endtask

  task automatic rd32(input string what, input logic [8:0] idx, input logic [31:0] exp);
    rd_chk(what, 1'b0, 1'b1, sel(2'h2, idx), 1'b0, {32'h0, exp}, ALL);
  endtask

  task automatic do_exit(input vm_exit_info_pkg::exit_event_t ev);
    i_exit_event <= ev;
    i_exit_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_exit_valid <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  task automatic side_err(input logic [31:0] num);
    i_instr_err_num <= num;
    i_instr_err_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_instr_err_valid <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk("side error", {32'h0, num}, {32'h0, o_instr_error});
    @(posedge i_sys_clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_delivery();
    vm_exit_info_pkg::exit_event_t ev;
    logic [2:0] kinds [6];
    logic [31:0] exp_err;
    logic [31:0] exp_len;
    kinds = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    exp_err = 32'h0;
    exp_len = 32'h0;
    rd32("info at reset", vm_exit_info_pkg::IDX_DELIVERY_INFO, 32'h0);
    foreach (kinds[i]) begin
      ev = '0;
      ev.in_delivery = 1'b1;
      ev.delivery.vector = 8'hF0 + 8'(i);
      ev.delivery.kind = kinds[i];
      ev.delivery.has_err_code = (kinds[i] == 3'h3);
      ev.delivery.err_code = 32'hC0DE0000 + 32'(i);
      ev.instr_len = 32'h00000002 + 32'(i);
      if (kinds[i] == 3'h3) exp_err = ev.delivery.err_code;
      if (kinds[i] == 3'h4 || kinds[i] == 3'h6) exp_len = ev.instr_len;
      do_exit(ev);
      rd_chk("info", 1'b0, 1'b1, sel(2'h2, 9'h008), 1'b0, {32'h0, 1'b1, 19'h0,
        ev.delivery.has_err_code, kinds[i], ev.delivery.vector}, INFO_MASK);
      rd32("delivery error", 9'h009, exp_err);
      rd32("length in delivery", 9'h00A, exp_len);
    end
    ev = '0;
    do_exit(ev);
    rd32("info no delivery", 9'h008, 32'h0);
  endtask

  // Exits never touch the error word; instruction exits fill length and detail
  task automatic t_instr();
    vm_exit_info_pkg::exit_event_t ev;
    side_err(32'h00000007);
    ev = '0;
    ev.cause = vm_exit_info_pkg::EXIT_INSTR;
    ev.instr_len = 32'h0000000F;
    ev.instr_detail = 32'h89ABCDEF;
    ev.io_regs = {4{64'hDEADDEADDEADDEAD}};
    do_exit(ev);
    rd32("instr length", 9'h00A, 32'h0000000F);
    rd32("instr detail", 9'h00B, 32'h89ABCDEF);
    rd32("instr error", 9'h000, 32'h00000007);
    chk("error port", 64'h7, {32'h0, o_instr_error});
  endtask

  task automatic t_io();
    vm_exit_info_pkg::exit_event_t ev;
    logic [63:0] v;
    ev = '0;
    ev.cause = vm_exit_info_pkg::EXIT_SMI_AFTER_IO;
    for (int k = 0; k < 4; k++) ev.io_regs[k] = 64'h1122334455667700 + 64'(k);
    do_exit(ev);
    ev.cause = vm_exit_info_pkg::EXIT_INSTR;
    ev.io_regs = '0;
    do_exit(ev);
    for (int k = 0; k < 4; k++) begin
      v = 64'h1122334455667700 + 64'(k);
      rd_chk("io full", 1'b0, 1'b1, sel(2'h3, 9'(k)), 1'b0, v, ALL);
      rd_chk("io narrow", 1'b0, 1'b0, sel(2'h3, 9'(k)), 1'b0, {32'h0, v[31:0]}, ALL);
    end
    // Outside 64-bit mode the upper operand half is ignored
    rd_chk("io upper ignored", 1'b0, 1'b0, sel(2'h3, 9'h000) | 64'h200000000, 1'b0,
      64'h0000000055667700, ALL);
  endtask

  task automatic t_bad();
    logic [63:0] b;
    logic [63:0] bad [10];
    b = sel(2'h2, 9'h008);
    bad = '{b | 64'h200000000, b | 64'h1000, b | 64'h8000, b | 64'h80000000, b | 64'h1,
      sel(2'h1, 9'h008) | 64'h1, b & ~64'hC00, sel(2'h2, 9'h001), b | 64'hC00,
      sel(2'h0, 9'h008)};
    foreach (bad[i]) begin
      side_err(32'h00000001);
      rd_chk("bad selector", 1'b0, 1'b1, bad[i], 1'b1, 64'h0, ALL);
      chk("bad error", {32'h0, vm_exit_info_pkg::ERR_BAD_SELECTOR}, {32'h0, o_instr_error});
    end
    side_err(32'h00000001);
    rd_chk("write info", 1'b1, 1'b1, b, 1'b1, 64'h0, ALL);
    chk("write error", {32'h0, vm_exit_info_pkg::ERR_WRITE_READ_ONLY}, {32'h0, o_instr_error});
    side_err(32'h00000001);
    rd_chk("write io", 1'b1, 1'b0, sel(2'h3, 9'h000), 1'b1, 64'h0, ALL);
    rd32("good read", 9'h000, vm_exit_info_pkg::ERR_WRITE_READ_ONLY);
  endtask

  // A request while the enable is low is never taken
  task automatic t_freeze();
    i_clk_en <= 1'b0;
    i_acc_req <= '{is_write: 1'b1, mode64: 1'b1, selector: 64'h200000000, wdata: 64'h0};
    i_acc_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_acc_valid <= 1'b0;
    @(posedge i_sys_clk);
    i_clk_en <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk("frozen done", 64'h0, {63'h0, o_acc_done});
    chk("frozen error", 64'hD, {32'h0, o_instr_error});
    @(posedge i_sys_clk);
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************
  // Run ends with no power removal, so no record needs flushing
  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    fails++;
    $display("[FAIL] watchdog expected finish seen timeout");
    wrap_up();
  end

  initial begin
    i_rst = 1'b1;
    i_clk_en = 1'b1;
    i_exit_valid = 1'b0;
    i_exit_event = '0;
    i_instr_err_valid = 1'b0;
    i_instr_err_num = 32'h0;
    i_acc_valid = 1'b0;
    i_acc_req = '0;
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    chk("error after reset", 64'h0, {32'h0, o_instr_error});
    t_delivery();
    t_instr();
    t_io();
    t_bad();
    t_freeze();
    wrap_up();
  end
endmodule // vm_field_encoding_exit_info_tb

`default_nettype wire
